// [verilog/oidf_consts.svh]
// constants for the octal input debounce filter
// Functional notes
// [R1] fast channels pass straight, no filtering
// [R2] slow channels go through debounce filter
// [R3] fixed 4 us low-pass always precedes debounce
// [R4] per-channel two-bit delay; 00 adds none
// [R5] delay codes 01/10/11 give 10/30/100 ms
// [R6] mode: 00 deglitch, 01 low-pass, 1x blanking
// [R7] parallel variant: low-pass only, fixed delay
// [R8] deglitch: output follows after stable debounce time
// [R9] deglitch: short changes are discarded
// [R10] sensor on reads 1, off reads 0
// [R11] outputs follow inputs after filtering
// [R12] open input reports logic low
// [R13] lockout: outputs hold, do not track
// [R14] low-pass: non-rolling up/down counter
// [R15] blanking: immediate update, reload, blind window
// [R16] selectors packed four channels per byte
// [R17] millisecond timing from prescaled clock tick
`ifndef OIDF_CONSTS_SVH
`define OIDF_CONSTS_SVH
`define OIDF_CLK_HZ        50_000_000
`define OIDF_FIXED_NS      4000
`define OIDF_FIXED_CYC     ((`OIDF_FIXED_NS * (`OIDF_CLK_HZ / 1_000_000) + 999) / 1000)
`define OIDF_TICK_US       1000
`define OIDF_TICK_CYC      (`OIDF_TICK_US * (`OIDF_CLK_HZ / 1_000_000))
`define OIDF_DLY_MS_01     10
`define OIDF_DLY_MS_10     30
`define OIDF_DLY_MS_11     100
`define OIDF_MODE_DEGLITCH 2'b00
`define OIDF_MODE_LOWPASS  2'b01
`define OIDF_SEL_W         2
`define OIDF_CH_PER_BYTE   4
`endif

// [verilog/oidf_pkg.sv]
// types for the octal input debounce filter
package oidf_pkg;
    typedef enum logic [1:0] {
        OIDF_DLY_NONE = 2'b00,
        OIDF_DLY_SHORT = 2'b01,
        OIDF_DLY_MED = 2'b10,
        OIDF_DLY_LONG = 2'b11
    } oidf_dly_e;
    typedef struct packed {
        logic [7:0] mode_lo;
        logic [7:0] mode_hi;
        logic [7:0] dly_lo;
        logic [7:0] dly_hi;
    } oidf_cfg_s;
    typedef logic [6:0] oidf_ms_t;
endpackage

// [verilog/oidf_channel.sv]
// one slow channel: fixed low-pass stage plus configurable debounce filter
`timescale 1ns/1ps
`include "oidf_consts.svh"
module oidf_channel
    import oidf_pkg::*;
#(
    parameter int FIXED_CYC = `OIDF_FIXED_CYC
) (
    input  wire logic       i_ref_clk,
    input  wire logic       i_reset,
    input  wire logic       i_ce,
    input  wire logic       i_hold,
    input  wire logic       i_tick,
    input  wire logic       i_in,
    input  wire logic [1:0] i_mode,
    input  wire oidf_ms_t   i_limit,
    output logic            o_out
);
    localparam int FW = $clog2(FIXED_CYC + 1);
    if (FIXED_CYC < 1) begin : g_bad_fixed
        $error("FIXED_CYC must be at least 1");
    end
    logic [FW-1:0] fcnt;
    logic          fixed_out;
    oidf_ms_t      cnt;
    logic          last_in;
    logic          deb;
    logic          zero_dly;
    assign zero_dly = (i_limit == '0);

    // fixed stage: up/down counter, held at zero, cleared when the output flips, always present
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            fcnt      <= '0;
            fixed_out <= 1'b0;
        end else if (i_ce && !i_hold) begin
            if (i_in != fixed_out) begin // [R3]
                if (fcnt == FW'(FIXED_CYC - 1)) begin
                    fixed_out <= i_in;
                    fcnt      <= '0;
                end else begin
                    fcnt <= fcnt + 1'b1;
                end
            end else if (fcnt != '0) begin
                fcnt <= fcnt - 1'b1;
            end
        end
    end

    // debounce stage, counted in ms ticks
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            cnt     <= '0;
            last_in <= 1'b0;
            deb     <= 1'b0;
        end else if (i_ce && !i_hold) begin // [R13]
            last_in <= fixed_out;
            if (zero_dly) begin
                deb <= fixed_out; // [R4]
                cnt <= '0;
            end else if (i_mode == `OIDF_MODE_DEGLITCH) begin
                if (fixed_out != last_in || fixed_out == deb) begin
                    cnt <= '0; // [R9]
                end else if (i_tick) begin
                    if (cnt >= i_limit) begin
                        deb <= fixed_out; // [R8]
                        cnt <= '0;
                    end else begin
                        cnt <= cnt + 1'b1;
                    end
                end
            end else if (i_mode == `OIDF_MODE_LOWPASS) begin
                if (i_tick) begin
                    if (fixed_out != deb) begin // [R14]
                        if (cnt + 1'b1 >= i_limit) begin
                            deb <= fixed_out;
                            cnt <= '0;
                        end else begin
                            cnt <= cnt + 1'b1;
                        end
                    end else if (cnt != '0) begin
                        cnt <= cnt - 1'b1;
                    end
                end
            end else begin
                if (fixed_out != last_in) begin
                    cnt <= i_limit; // [R15]
                    if (cnt == '0) begin
                        deb <= fixed_out;
                    end
                end else if (cnt == '0) begin
                    deb <= fixed_out;
                end else if (i_tick) begin
                    cnt <= cnt - 1'b1;
                end
            end
        end
    end
    assign o_out = deb;

    a_lp_saturate: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        (i_ce && !i_hold && i_mode == `OIDF_MODE_LOWPASS && !zero_dly) |=> (cnt <= i_limit))
        else $error("low-pass counter passed its limit"); // [R14]
    a_dg_stable: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        (i_ce && !i_hold && i_mode == `OIDF_MODE_DEGLITCH && !zero_dly && fixed_out != last_in)
        |=> $stable(deb))
        else $error("deglitch output moved on an unstable input"); // [R9]
    a_zero_follow: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        (i_ce && !i_hold && zero_dly) |=> (deb == $past(fixed_out)))
        else $error("zero delay did not follow fixed stage"); // [R4]
endmodule

// [verilog/oidf_top.sv]
// octal input debounce filter: fast pass-through and eight filtered slow channels
`timescale 1ns/1ps
`include "oidf_consts.svh"
module oidf_top
    import oidf_pkg::*;
#(
    parameter int        N_CH        = 8,
    parameter int        TICK_CYC    = `OIDF_TICK_CYC,
    parameter bit        PARALLEL    = 1'b0,
    parameter logic [1:0] FIXED_DLY  = 2'b00
) (
    input  wire logic            i_ref_clk,
    input  wire logic            i_reset,
    input  wire logic            i_ce,
    input  wire logic            i_supply_lockout,
    input  wire logic [N_CH-1:0] i_fast_field_input,
    input  wire logic [N_CH-1:0] i_slow_field_input,
    input  wire oidf_cfg_s       i_cfg,
    output logic [N_CH-1:0]      o_fast_channel_output,
    output logic [N_CH-1:0]      o_slow_channel_output
);
    if (N_CH != 8) begin : g_bad_nch
        $error("N_CH must be 8");
    end
    if (TICK_CYC < 2) begin : g_bad_tick
        $error("TICK_CYC too small");
    end
    localparam int TW = $clog2(TICK_CYC);

    logic [N_CH-1:0] s1;
    logic [N_CH-1:0] s2;
    logic [N_CH-1:0] s3;
    logic [N_CH-1:0] slow_in;
    logic [N_CH-1:0] f1;
    logic [N_CH-1:0] f2;
    logic [N_CH-1:0] f3;
    logic [2:0]      lk;
    logic [TW-1:0]   pre;
    logic            tick;
    logic            hold;
    logic [N_CH-1:0] filt;
    logic [15:0]     mode_all;
    logic [15:0]     dly_all;

    // three-flop synchronisers, change taken when stages two and three agree
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            f1 <= '0;
            f2 <= '0;
            f3 <= '0;
            lk <= '0;
            hold <= 1'b0;
            slow_in <= '0; // [R12]
        end else if (i_ce) begin
            s1 <= i_slow_field_input;
            s2 <= s1;
            s3 <= s2;
            f1 <= i_fast_field_input;
            f2 <= f1;
            f3 <= f2;
            lk <= {lk[1:0], i_supply_lockout};
            if (lk[1] == lk[2]) begin
                hold <= lk[2]; // [R13]
            end
            for (int k = 0; k < N_CH; k++) begin
                if (s2[k] == s3[k]) begin
                    slow_in[k] <= s3[k]; // [R10]
                end
            end
        end
    end
    // millisecond tick prescaler
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            pre  <= '0;
            tick <= 1'b0;
        end else if (i_ce) begin
            tick <= (pre == TW'(TICK_CYC - 1)); // [R17]
            if (pre == TW'(TICK_CYC - 1)) begin
                pre <= '0;
            end else begin
                pre <= pre + 1'b1;
            end
        end
    end

    // selectors: four channels a byte, channel 0 in the low bits
    assign mode_all = {i_cfg.mode_hi, i_cfg.mode_lo}; // [R16]
    assign dly_all  = {i_cfg.dly_hi, i_cfg.dly_lo};

    function automatic oidf_ms_t limit_of(input logic [1:0] code);
        case (oidf_dly_e'(code))
            OIDF_DLY_NONE:  limit_of = '0; // [R4]
            OIDF_DLY_SHORT: limit_of = 7'(`OIDF_DLY_MS_01); // [R5]
            OIDF_DLY_MED:   limit_of = 7'(`OIDF_DLY_MS_10);
            OIDF_DLY_LONG:  limit_of = 7'(`OIDF_DLY_MS_11);
            default:        limit_of = '0;
        endcase
    endfunction

    for (genvar g = 0; g < N_CH; g++) begin : g_ch
        logic [1:0] m;
        logic [1:0] d;
        assign m = PARALLEL ? `OIDF_MODE_LOWPASS : mode_all[g*`OIDF_SEL_W +: `OIDF_SEL_W]; // [R7]
        assign d = PARALLEL ? FIXED_DLY : dly_all[g*`OIDF_SEL_W +: `OIDF_SEL_W];
        oidf_channel u_ch (
            .i_ref_clk (i_ref_clk),
            .i_reset   (i_reset),
            .i_ce      (i_ce),
            .i_hold    (hold),
            .i_tick    (tick),
            .i_in      (slow_in[g]), // [R2]
            .i_mode    (m), // [R6]
            .i_limit   (limit_of(d)),
            .o_out     (filt[g])
        );
    end

    // output registers; frozen during supply lockout
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            o_fast_channel_output <= '0;
            o_slow_channel_output <= '0;
        end else if (i_ce && !hold) begin // [R13]
            for (int k = 0; k < N_CH; k++) begin
                if (f2[k] == f3[k]) begin
                    o_fast_channel_output[k] <= f3[k]; // [R1]
                end
            end
            o_slow_channel_output <= filt; // [R11]
        end
    end

    a_fast_pass: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        (i_ce && !hold && f2 == f3) |=> (o_fast_channel_output == $past(f3)))
        else $error("fast output did not pass input"); // [R1]
    a_lock_hold: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        (hold) |=> $stable(o_slow_channel_output))
        else $error("slow output moved during lockout"); // [R13]
    a_tick_period: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        (i_ce && tick) |=> !tick)
        else $error("tick lasted more than one cycle"); // [R17]
    a_slow_follow: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        (i_ce && !hold) |=> (o_slow_channel_output == $past(filt)))
        else $error("slow output did not take filter result"); // [R11]
    a_sync_agree: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        (i_ce && s2 == s3) |=> (slow_in == $past(s3)))
        else $error("synchroniser did not take agreed value"); // [R10]
endmodule

// [tb/oidf_field.sv]
// field sensor model: sensed levels, open inputs read low
`timescale 1ns/1ps
module oidf_field (
    input  wire logic [7:0] i_fast_on,
    input  wire logic [7:0] i_slow_on,
    input  wire logic [7:0] i_open,
    output logic      [7:0] o_fast,
    output logic      [7:0] o_slow
);
    assign o_fast = i_fast_on & ~i_open;
    assign o_slow = i_slow_on & ~i_open;
endmodule

// [tb/octal_input_debounce_filter_bench.sv]
// bench for the octal input debounce filter
`timescale 1ns/1ps
`include "oidf_consts.svh"
module octal_input_debounce_filter_bench;
    import oidf_pkg::*;
    localparam int TK = 10;
    localparam int FX = `OIDF_FIXED_CYC;
    logic       i_ref_clk = 1'b0;
    logic       i_reset   = 1'b1;
    logic       lock      = 1'b0;
    logic       ce        = 1'b1;
    logic [7:0] f_on      = '0;
    logic [7:0] s_on      = '0;
    logic [7:0] opn       = '0;
    logic [7:0] f_in, s_in, f_out, s_out, p_out;
    oidf_cfg_s  cfg       = '0;
    int         miscompares = 0;
    int         cmp_count   = 0;
    int         dl [4] = '{0, `OIDF_DLY_MS_01 * TK, `OIDF_DLY_MS_10 * TK, `OIDF_DLY_MS_11 * TK};
    always #10 i_ref_clk = ~i_ref_clk;
    oidf_field oidf_field_inst (.i_fast_on(f_on), .i_slow_on(s_on), .i_open(opn), .o_fast(f_in), .o_slow(s_in));
    oidf_top #(.TICK_CYC(TK)) oidf_top_inst (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_ce(ce),
        .i_supply_lockout(lock), .i_fast_field_input(f_in), .i_slow_field_input(s_in), .i_cfg(cfg),
        .o_fast_channel_output(f_out), .o_slow_channel_output(s_out));
    oidf_top #(.TICK_CYC(TK), .PARALLEL(1'b1), .FIXED_DLY(2'b10)) oidf_par_inst (.i_ref_clk(i_ref_clk),
        .i_reset(i_reset), .i_ce(ce), .i_supply_lockout(lock), .i_fast_field_input(f_in),
        .i_slow_field_input(s_in), .i_cfg(cfg), .o_fast_channel_output(), .o_slow_channel_output(p_out));
    task automatic wrap_up();
        if (miscompares == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask
    task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wt(input string nm, input logic [7:0] m, input logic [7:0] v, input int lim);
        int n;
        for (n = 0; n < lim && (s_out & m) !== v; n++) cyc(1);
        chk(nm, s_out & m, v);
        if (n == lim) wrap_up();
    endtask
    task automatic sc_fast();
        chk("reset slow", s_out, 8'h00);
        f_on = 8'hA5;
        cyc(3);
        chk("fast early", f_out, 8'h00);
        cyc(1);
        chk("fast out", f_out, 8'hA5);
        ce = 1'b0;
        f_on = 8'h5A;
        cyc(8);
        chk("ce freeze", f_out, 8'hA5);
        ce = 1'b1;
        cyc(4);
        chk("ce resume", f_out, 8'h5A);
    endtask
    task automatic sc_delay();
        int at [8] = '{default: 0};
        int ap [8] = '{default: 0};
        cfg = '{mode_lo: 8'h55, mode_hi: 8'h00, dly_lo: 8'hE4, dly_hi: 8'hE4};
        s_on = 8'hFF;
        for (int c = 1; c <= 1400; c++) begin
            cyc(1);
            for (int k = 0; k < 8; k++) begin
                if (s_out[k] === 1'b1 && at[k] == 0) at[k] = c;
                if (p_out[k] === 1'b1 && ap[k] == 0) ap[k] = c;
            end
        end
        for (int k = 0; k < 8; k++) begin
            chk("slow delay", 8'(at[k] > FX + dl[k % 4] - 12 && at[k] < FX + dl[k % 4] + 20), 8'h01);
            chk("parallel delay", 8'(ap[k] > FX + dl[2] - 12 && ap[k] < FX + dl[2] + 20), 8'h01);
        end
        s_on = 8'h00;
        cyc(1500);
        chk("slow fall", s_out, 8'h00);
        chk("parallel fall", p_out, 8'h00);
    endtask
    task automatic sc_deglitch();
        logic seen;
        seen = 1'b0;
        cfg = '{mode_lo: 8'h38, mode_hi: 8'h00, dly_lo: 8'h3F, dly_hi: 8'h00};
        cyc(2);
        s_on = 8'h09;
        cyc(150);
        s_on = 8'h01;
        cyc(250);
        s_on = 8'h00;
        for (int c = 0; c < 1500; c++) begin
            cyc(1);
            seen = seen | s_out[0] | s_out[3];
        end
        chk("glitch dropped", {7'h00, seen}, 8'h00);
        s_on = 8'h01;
        cyc(FX + 900);
        chk("deglitch early", s_out & 8'h01, 8'h00);
        wt("deglitch late", 8'h01, 8'h01, 140);
    endtask
    task automatic sc_blank();
        s_on = 8'h07;
        wt("blank lead", 8'h06, 8'h06, FX + 15);
        cyc(100);
        s_on = 8'h01;
        cyc(FX + 900);
        chk("blank blind", s_out & 8'h06, 8'h06);
        wt("blank end", 8'h06, 8'h00, 150);
    endtask
    task automatic sc_lock();
        lock = 1'b1;
        cyc(5);
        opn = 8'h0F;
        f_on = 8'hFF;
        cyc(10);
        chk("lockout hold", f_out, 8'h5A);
        lock = 1'b0;
        cyc(10);
        chk("open low", f_out, 8'hF0);
    endtask
    initial begin
        cyc(20);
        i_reset = 1'b0;
        sc_fast();
        sc_delay();
        sc_deglitch();
        sc_blank();
        sc_lock();
        wrap_up();
    end
endmodule
